// ==== rtl/clkss_pkg.sv ====
// shared constants and types of the sample clock source selection block
package clkss_pkg;

    // register offsets
    localparam logic [15:0] OFS_SAMPLE_RATE_REQUEST     = 16'h4e20;
    localparam logic [15:0] OFS_CLOCK_OUTPUT_ENABLE     = 16'h4e8e;
    localparam logic [15:0] OFS_CLOCK_OUTPUT_FREQUENCY  = 16'h4e8f;
    localparam logic [15:0] OFS_CLOCK_SOURCE_SELECT     = 16'h4ee8;
    localparam logic [15:0] OFS_CLOCK_SOURCES_AVAILABLE = 16'h4ee9;

    // clock mode codes, one bit each, so they double as mask bits
    localparam logic [31:0] MODE_PRIMARY_QUARTZ_PLL    = 32'h0000_0001;
    localparam logic [31:0] MODE_SECONDARY_OSCILLATOR  = 32'h0000_0004;
    localparam logic [31:0] MODE_EXTERNAL_REFERENCE    = 32'h0000_0020;
    localparam logic [31:0] MODE_BACKPLANE_REFERENCE   = 32'h0000_0040;

    // field positions of the clock output enable register
    localparam int          CLKOUT_EN_BIT = 0;

    // reset values
    localparam logic [31:0] RST_MODE        = MODE_PRIMARY_QUARTZ_PLL;
    localparam logic [63:0] RST_RATE        = 64'h0000_0000_0098_9680;
    localparam logic        RST_CLKOUT_EN   = 1'b0;

    // achievable rate granularity and range (plain defaults)
    localparam int          FINE_SHIFT   = 0;
    localparam int          COARSE_SHIFT = 10;
    localparam logic [63:0] RATE_MIN     = 64'h0000_0000_0000_c350;
    localparam logic [63:0] RATE_MAX     = 64'h0000_0000_4a81_7c80;

    // pll lock timing
    localparam longint      SYS_CLK_HZ    = 10_000_000;
    localparam longint      LOCK_MIN_MS   = 10;
    localparam longint      LOCK_MAX_MS   = 200;
    localparam int unsigned LOCK_MIN_CYC  =
        int'((LOCK_MIN_MS * SYS_CLK_HZ + 999) / 1000);
    localparam int unsigned LOCK_MAX_CYC  =
        int'((LOCK_MAX_MS * SYS_CLK_HZ) / 1000);

    // settings handed to the pll at start
    typedef struct packed {
        logic [31:0] mode;
        logic [63:0] rate;
    } clkss_cfg_t;

    typedef enum logic [2:0] {
        LK_IDLE = 3'b001,
        LK_WAIT = 3'b010,
        LK_FAIL = 3'b100
    } clkss_lock_st_t;

endpackage : clkss_pkg

// ==== rtl/clkss_rate_calc.sv ====
// nearest achievable sample rate for a requested rate and clock mode
`timescale 1ns/1ps
`default_nettype none
module clkss_rate_calc
    import clkss_pkg::*;
(
    input  wire logic [31:0] mode_in,
    input  wire logic [63:0] req_in,
    output logic      [63:0] rate_out
);

    // round to nearest multiple of 2**shift
    function automatic logic [63:0] round_rate(input logic [63:0] r,
                                               input int          sh);
        logic [63:0] half;
        logic [63:0] mask;
        half = (sh == 0) ? 64'h0 : (64'h1 << (sh - 1));
        mask = ~((64'h1 << sh) - 64'h1);
        round_rate = (r + half) & mask;
    endfunction : round_rate

    wire logic [63:0] clamped;
    wire logic [63:0] fine_rate;
    wire logic [63:0] coarse_rate;
    wire logic        fine_mode;

    assign clamped = (req_in < RATE_MIN) ? RATE_MIN :
                     (req_in > RATE_MAX) ? RATE_MAX : req_in;
    // the primary quartz is programmable, so it gets the fine grid
    assign fine_mode   = (mode_in == MODE_PRIMARY_QUARTZ_PLL);
    assign fine_rate   = round_rate(clamped, FINE_SHIFT);
    assign coarse_rate = round_rate(clamped, COARSE_SHIFT);
    // rounding up can step past the ceiling; fall back one step
    assign rate_out = fine_mode ? fine_rate :
                      (coarse_rate > RATE_MAX) ?
                      (coarse_rate - (64'h1 << COARSE_SHIFT)) : coarse_rate;

endmodule : clkss_rate_calc
`default_nettype wire

// ==== rtl/clkss_lock_wait.sv ====
// pll lock wait after a start with changed clock settings
`timescale 1ns/1ps
`default_nettype none
module clkss_lock_wait
    import clkss_pkg::*;
#(
    parameter int unsigned MIN_CYC = LOCK_MIN_CYC,
    parameter int unsigned MAX_CYC = LOCK_MAX_CYC
) (
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    input  wire logic start_in,
    input  wire logic need_lock_in,
    input  wire logic pll_locked_in,
    output logic      done_out,
    output logic      err_out,
    output logic      stable_out
);

    clkss_lock_st_t state_ff;
    clkss_lock_st_t nxt_state;
    logic [31:0]    cnt_ff;
    logic           done_ff;
    logic           err_ff;
    logic           stable_ff;

    wire logic min_ok;
    wire logic timeout;
    assign min_ok  = (cnt_ff >= MIN_CYC - 1);
    assign timeout = (cnt_ff >= MAX_CYC - 1);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LK_IDLE, LK_FAIL: begin
                // after a failed lock the pll is not trusted, so wait again
                if (start_in && (need_lock_in || state_ff == LK_FAIL))
                    nxt_state = LK_WAIT;
                else if (start_in) nxt_state = LK_IDLE;
            end
            LK_WAIT: begin
                if (min_ok && pll_locked_in) nxt_state = LK_IDLE;
                else if (timeout) nxt_state = LK_FAIL;
            end
            default: nxt_state = LK_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff  <= LK_IDLE;
            cnt_ff    <= 32'h0;
            done_ff   <= 1'b0;
            err_ff    <= 1'b0;
            stable_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= (state_ff == LK_WAIT) ? cnt_ff + 32'h1 : 32'h0;
            done_ff  <= (start_in && !need_lock_in && state_ff == LK_IDLE)
                     || (state_ff == LK_WAIT && min_ok && pll_locked_in);
            if (state_ff == LK_WAIT && timeout && !(min_ok && pll_locked_in))
                err_ff <= 1'b1;
            else if (start_in && state_ff != LK_WAIT)
                err_ff <= 1'b0;
            if (nxt_state == LK_WAIT || nxt_state == LK_FAIL)
                stable_ff <= 1'b0;
            else if (state_ff == LK_WAIT || start_in)
                stable_ff <= 1'b1;
        end
    end

    assign done_out   = done_ff;
    assign err_out    = err_ff;
    assign stable_out = stable_ff;

    lock_min_wait_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (done_ff && $past(state_ff) == LK_WAIT) |-> $past(cnt_ff) >= MIN_CYC - 1)
        else $error("lock reported before the least settle time");

    lock_fail_err_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (state_ff == LK_WAIT && timeout && !pll_locked_in) |=> err_ff && !stable_ff)
        else $error("lock timeout did not raise the error");

endmodule : clkss_lock_wait
`default_nettype wire

// ==== rtl/clkss_top.sv ====
// sample clock source select, rate request and clock output control
//
// Behaviour
// - mode code 1 selects the primary programmable quartz as pll reference
// - mode code 4 selects the optional secondary quartz as pll reference
// - mode code 32 selects the external clock input as pll reference
// - mode code 64, backplane variant only, selects backplane reference
// - available-modes register sets a bit only for each supported mode
// - clock mode register writes of a supported single mode select it, others are ignored; reads return it
// - a sample-rate write requests an internal rate in whole hertz
// - a sample-rate read returns the nearest achievable rate
// - clock output enable 1 drives sample clock, 0 tristates it
// - output frequency register reports the clock at the output
// - clock output enable acts the same for every clock source
// - primary quartz with pll is the default source
// - external reference is divided and multiplied by the pll
// - secondary quartz goes via pll, rate readback on the coarse grid as external mode
// - sync master distributes its clock from primary quartz or ext ref
// - start after a clock change waits for pll lock, up to 200 ms
// - pll failing to lock makes start fail with a not-locked error
`timescale 1ns/1ps
`default_nettype none
module clkss_top
    import clkss_pkg::*;
#(
    parameter int unsigned LOCK_MIN_CYCLES = LOCK_MIN_CYC,
    parameter int unsigned LOCK_MAX_CYCLES = LOCK_MAX_CYC
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [63:0] reg_wdata_in,
    output logic      [63:0] reg_rdata_out,
    output logic             reg_rvalid_out,
    input  wire logic        quartz2_fitted_in,
    input  wire logic        backplane_variant_in,
    input  wire logic        sync_master_in,
    input  wire logic        card_start_in,
    input  wire logic        pll_locked_in,
    input  wire logic        sample_clk_in,
    output clkss_cfg_t       pll_cfg_out,
    output logic       [3:0] pll_ref_sel_out,
    output logic             start_done_out,
    output logic             pll_not_locked_error_out,
    output logic             clock_stable_out,
    output logic             clkout_out,
    output logic             clkout_oe_out,
    output logic             sync_clk_out,
    output logic             sync_clk_oe_out
);

    logic        caps_ok_ff;
    logic        has_q2_ff;
    logic        has_bp_ff;
    logic [31:0] mode_ff;
    logic [63:0] rate_req_ff;
    logic        clkout_en_ff;
    clkss_cfg_t  cfg_ff;
    logic        cfg_valid_ff;
    logic [3:0]  ref_sel_ff;
    logic [63:0] rdata_ff;
    logic        rvalid_ff;
    logic        clkout_ff;
    logic        clkout_oe_ff;
    logic        sync_clk_ff;
    logic        sync_oe_ff;

    function automatic logic single_bit(input logic [31:0] v);
        single_bit = (v != 32'h0) && ((v & (v - 32'h1)) == 32'h0);
    endfunction : single_bit

    // straps are caught on the first clock after reset release
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            caps_ok_ff <= 1'b0;
            has_q2_ff  <= 1'b0;
            has_bp_ff  <= 1'b0;
        end else if (!caps_ok_ff) begin
            caps_ok_ff <= 1'b1;
            has_q2_ff  <= quartz2_fitted_in;
            has_bp_ff  <= backplane_variant_in;
        end
    end

    wire logic [31:0] avail_mask;
    assign avail_mask = MODE_PRIMARY_QUARTZ_PLL | MODE_EXTERNAL_REFERENCE
                      | (has_q2_ff ? MODE_SECONDARY_OSCILLATOR : 32'h0)
                      | (has_bp_ff ? MODE_BACKPLANE_REFERENCE : 32'h0);

    wire logic wr_rate;
    wire logic wr_clkout;
    wire logic wr_mode;
    wire logic mode_ok;
    assign wr_rate   = reg_wr_in && (reg_addr_in == OFS_SAMPLE_RATE_REQUEST);
    assign wr_clkout = reg_wr_in && (reg_addr_in == OFS_CLOCK_OUTPUT_ENABLE);
    assign wr_mode   = reg_wr_in && (reg_addr_in == OFS_CLOCK_SOURCE_SELECT);
    assign mode_ok   = single_bit(reg_wdata_in[31:0])
                    && ((reg_wdata_in[31:0] & ~avail_mask) == 32'h0);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_ff      <= RST_MODE;
            rate_req_ff  <= RST_RATE;
            clkout_en_ff <= RST_CLKOUT_EN;
        end else begin
            if (wr_mode && mode_ok)
                mode_ff <= reg_wdata_in[31:0];
            if (wr_rate)
                rate_req_ff <= reg_wdata_in;
            if (wr_clkout)
                clkout_en_ff <= reg_wdata_in[CLKOUT_EN_BIT];
        end
    end

    wire logic [63:0] pend_rate;
    wire logic [63:0] run_rate;

    clkss_rate_calc u_pend_rate (
        .mode_in  (mode_ff),
        .req_in   (rate_req_ff),
        .rate_out (pend_rate)
    );

    clkss_rate_calc u_run_rate (
        .mode_in  (cfg_ff.mode),
        .req_in   (cfg_ff.rate),
        .rate_out (run_rate)
    );

    wire logic cfg_changed;
    assign cfg_changed = !cfg_valid_ff || (cfg_ff.mode != mode_ff)
                      || (cfg_ff.rate != pend_rate);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_ff       <= '{mode: RST_MODE, rate: RST_RATE};
            cfg_valid_ff <= 1'b0;
        end else if (card_start_in) begin
            cfg_ff       <= '{mode: mode_ff, rate: pend_rate};
            cfg_valid_ff <= 1'b1;
        end
    end

    // pll reference select from committed mode
    wire logic [3:0] ref_sel;
    assign ref_sel = {cfg_ff.mode == MODE_BACKPLANE_REFERENCE,
                      cfg_ff.mode == MODE_EXTERNAL_REFERENCE,
                      cfg_ff.mode == MODE_SECONDARY_OSCILLATOR,
                      cfg_ff.mode == MODE_PRIMARY_QUARTZ_PLL};

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            ref_sel_ff <= 4'h1;
        else
            ref_sel_ff <= ref_sel;
    end

    logic lock_done;
    logic lock_err;
    logic lock_stable;

    clkss_lock_wait #(
        .MIN_CYC (LOCK_MIN_CYCLES),
        .MAX_CYC (LOCK_MAX_CYCLES)
    ) u_lock (
        .sys_clk_in    (sys_clk_in),
        .rst_n_in      (rst_n_in),
        .start_in      (card_start_in),
        .need_lock_in  (cfg_changed),
        .pll_locked_in (pll_locked_in),
        .done_out      (lock_done),
        .err_out       (lock_err),
        .stable_out    (lock_stable)
    );

    // register reads, answered one cycle later; unmapped reads give zero
    wire logic [63:0] rd_mux;
    assign rd_mux =
        (reg_addr_in == OFS_SAMPLE_RATE_REQUEST)     ? pend_rate :
        (reg_addr_in == OFS_CLOCK_OUTPUT_ENABLE)     ? {63'h0, clkout_en_ff} :
        // frequency at the output, zero while tristated
        (reg_addr_in == OFS_CLOCK_OUTPUT_FREQUENCY)  ?
            (clkout_en_ff ? run_rate : 64'h0) :
        (reg_addr_in == OFS_CLOCK_SOURCE_SELECT)     ? {32'h0, mode_ff} :
        (reg_addr_in == OFS_CLOCK_SOURCES_AVAILABLE) ? {32'h0, avail_mask} :
        64'h0;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff  <= 64'h0;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd_in;
            if (reg_rd_in)
                rdata_ff <= rd_mux;
        end
    end

    // clock output, same path for every source
    // the pll itself is outside; sample_clk_in is its output
    wire logic sync_src_ok;
    // sync source must be primary quartz or the external reference
    assign sync_src_ok = (cfg_ff.mode == MODE_PRIMARY_QUARTZ_PLL)
                      || (cfg_ff.mode == MODE_EXTERNAL_REFERENCE);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clkout_ff    <= 1'b0;
            clkout_oe_ff <= 1'b0;
            sync_clk_ff  <= 1'b0;
            sync_oe_ff   <= 1'b0;
        end else begin
            clkout_ff    <= sample_clk_in;
            clkout_oe_ff <= clkout_en_ff;
            sync_clk_ff  <= sample_clk_in;
            sync_oe_ff   <= sync_master_in && sync_src_ok && lock_stable;
        end
    end

    assign reg_rdata_out            = rdata_ff;
    assign reg_rvalid_out           = rvalid_ff;
    assign pll_cfg_out              = cfg_ff;
    assign pll_ref_sel_out          = ref_sel_ff;
    assign start_done_out           = lock_done;
    assign pll_not_locked_error_out = lock_err;
    assign clock_stable_out         = lock_stable;
    assign clkout_out               = clkout_ff;
    assign clkout_oe_out            = clkout_oe_ff;
    assign sync_clk_out             = sync_clk_ff;
    assign sync_clk_oe_out          = sync_oe_ff;

    mode_reject_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (wr_mode && !mode_ok) |=> $stable(mode_ff))
        else $error("unsupported mode write changed the mode");

    mode_accept_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (wr_mode && mode_ok) |=> mode_ff == $past(reg_wdata_in[31:0]))
        else $error("supported mode write not taken");

    avail_mask_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        caps_ok_ff |-> (avail_mask[2] == has_q2_ff)
                    && (avail_mask[6] == has_bp_ff) && avail_mask[0])
        else $error("available mask does not match fitted sources");

    rate_read_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in == OFS_SAMPLE_RATE_REQUEST)
            |=> rvalid_ff && rdata_ff == $past(pend_rate))
        else $error("rate read did not return achievable rate");

    clkout_oe_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        wr_clkout |=> ##1 clkout_oe_ff == $past(reg_wdata_in[CLKOUT_EN_BIT], 2))
        else $error("clock output enable does not follow write");

    commit_start_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        !card_start_in |=> $stable(cfg_ff))
        else $error("pll settings changed without a start");

    ref_select_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (cfg_ff.mode == MODE_EXTERNAL_REFERENCE && $stable(cfg_ff))
            |=> ref_sel_ff == 4'h4)
        else $error("external mode did not select external reference");

    default_mode_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (!cfg_valid_ff && !card_start_in) |=> ref_sel_ff == 4'h1)
        else $error("default source is not the primary quartz");

    sync_gate_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (!sync_master_in || !lock_stable) |=> !sync_oe_ff)
        else $error("sync clock driven while not master or not stable");

    freq_tristate_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in == OFS_CLOCK_OUTPUT_FREQUENCY
            && !clkout_en_ff) |=> rdata_ff == 64'h0)
        else $error("frequency read while tristated is not zero");

    clkout_copy_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        1'b1 |=> (clkout_ff == $past(sample_clk_in))
            && (clkout_oe_ff == $past(clkout_en_ff)))
        else $error("clock output path depends on more than enable");

    done_locked_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (lock_done && !$past(card_start_in)) |-> $past(pll_locked_in))
        else $error("start reported done without pll lock");

endmodule : clkss_top
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the sample clock source select block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import clkss_pkg::*;

    localparam int LMIN = 8;
    localparam int LMAX = 40;

    typedef struct packed {
        logic        wr;
        logic [15:0] a;
        logic [63:0] d;
        logic [63:0] e;
    } clkss_row_t;

    // straps: secondary quartz fitted, no backplane, so mask is 1|4|32
    localparam clkss_row_t ROWS [18] = '{
        '{1'b0, OFS_CLOCK_SOURCES_AVAILABLE, 64'h0, 64'h25},
        '{1'b0, OFS_CLOCK_SOURCE_SELECT, 64'h0, 64'h1},
        '{1'b0, OFS_SAMPLE_RATE_REQUEST, 64'h0, 64'h98_9680},
        '{1'b1, OFS_CLOCK_SOURCE_SELECT, 64'h20, 64'h20},
        '{1'b1, OFS_CLOCK_SOURCE_SELECT, 64'h40, 64'h20},
        '{1'b1, OFS_CLOCK_SOURCE_SELECT, 64'h4, 64'h4},
        '{1'b1, OFS_CLOCK_SOURCE_SELECT, 64'h3, 64'h4},
        '{1'b1, OFS_SAMPLE_RATE_REQUEST, 64'hf_4240, 64'hf_4400},
        '{1'b1, OFS_CLOCK_SOURCE_SELECT, 64'h1, 64'h1},
        '{1'b0, OFS_SAMPLE_RATE_REQUEST, 64'h0, 64'hf_4240},
        '{1'b1, OFS_SAMPLE_RATE_REQUEST, 64'h3b9_aca0, 64'h3b9_aca0},
        '{1'b1, OFS_SAMPLE_RATE_REQUEST, 64'ha, RATE_MIN},
        '{1'b1, OFS_SAMPLE_RATE_REQUEST, 64'h1_0000_0000, RATE_MAX},
        '{1'b0, 16'h4e21, 64'h0, 64'h0},
        '{1'b1, OFS_CLOCK_SOURCES_AVAILABLE, 64'hff, 64'h25},
        '{1'b1, OFS_CLOCK_OUTPUT_ENABLE, 64'hffff_ffff_0000_0001, 64'h1},
        '{1'b0, OFS_CLOCK_OUTPUT_FREQUENCY, 64'h0, 64'h98_9680},
        '{1'b1, OFS_CLOCK_OUTPUT_FREQUENCY, 64'h5, 64'h98_9680}
    };

    logic        sys_clk;
    logic        rst_n;
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [63:0] wdata;
    logic [63:0] rdata;
    logic        rvalid;
    logic        q2_fitted;
    logic        bp_variant;
    logic        sync_master;
    logic        start;
    logic        locked;
    logic        sclk;
    clkss_cfg_t  cfg;
    logic [3:0]  ref_sel;
    logic        done;
    logic        err;
    logic        stable;
    logic        clkout;
    logic        clkout_oe;
    logic        sync_clk;
    logic        sync_oe;
    int          num_errors;
    int          tests_run;
    int          n;

    clkss_top #(.LOCK_MIN_CYCLES(LMIN), .LOCK_MAX_CYCLES(LMAX)) dut_u (
        .sys_clk_in              (sys_clk),
        .rst_n_in                (rst_n),
        .reg_wr_in               (wr),
        .reg_rd_in               (rd),
        .reg_addr_in             (addr),
        .reg_wdata_in            (wdata),
        .reg_rdata_out           (rdata),
        .reg_rvalid_out          (rvalid),
        .quartz2_fitted_in       (q2_fitted),
        .backplane_variant_in    (bp_variant),
        .sync_master_in          (sync_master),
        .card_start_in           (start),
        .pll_locked_in           (locked),
        .sample_clk_in           (sclk),
        .pll_cfg_out             (cfg),
        .pll_ref_sel_out         (ref_sel),
        .start_done_out          (done),
        .pll_not_locked_error_out(err),
        .clock_stable_out        (stable),
        .clkout_out              (clkout),
        .clkout_oe_out           (clkout_oe),
        .sync_clk_out            (sync_clk),
        .sync_clk_oe_out         (sync_oe)
    );

    always #50 sys_clk = ~sys_clk;

    task automatic end_of_test;
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_val(input string nm, input logic [63:0] e,
                           input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task automatic chk_cnt(input string nm, input int lo, input int hi,
                           input int g);
        tests_run++;
        if (g < lo || g > hi) begin
            num_errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_cnt

    task automatic reg_write(input logic [15:0] a, input logic [63:0] d);
        @(posedge sys_clk);
        #1;
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge sys_clk);
        #1;
        wr = 1'b0;
    endtask : reg_write

    task automatic check_rd(input string nm, input logic [15:0] a,
                            input logic [63:0] e);
        @(posedge sys_clk);
        #1;
        rd = 1'b1;
        addr = a;
        @(posedge sys_clk);
        #1;
        rd = 1'b0;
        chk_val("rvalid", 64'h1, {63'h0, rvalid});
        chk_val(nm, e, rdata);
    endtask : check_rd

    // waits for done, or for the error level when a failure is wanted
    task automatic do_start(input logic want_err, output int cnt);
        @(posedge sys_clk);
        #1;
        start = 1'b1;
        @(posedge sys_clk);
        #1;
        start = 1'b0;
        cnt = 0;
        while (!((want_err ? err : done) === 1'b1) && cnt < LMAX + 5) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
    endtask : do_start

    // output copies the sample clock one edge late while enabled
    task automatic chk_clkout;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            #1;
            sclk = i[0];
            @(posedge sys_clk);
            #1;
            chk_val("clkout", {63'h0, i[0]}, {63'h0, clkout});
            chk_val("sync_clk", {63'h0, i[0]}, {63'h0, sync_clk});
        end
    endtask : chk_clkout

    task automatic do_reset(input logic q2, input logic bp);
        @(posedge sys_clk);
        #1;
        rst_n = 1'b0;
        q2_fitted = q2;
        bp_variant = bp;
        repeat (3) @(posedge sys_clk);
        #1;
        chk_val("cfg_mode", 64'(RST_MODE), {32'h0, cfg.mode});
        chk_val("cfg_rate", RST_RATE, cfg.rate);
        chk_val("ref_sel", 64'h1, {60'h0, ref_sel});
        chk_val("status", 64'h0, {58'h0, done, err, stable, rvalid,
                                  clkout_oe, sync_oe});
        rst_n = 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask : do_reset

    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        {wr, rd, start, locked, sclk, sync_master} = '0;
        addr = 16'h0;
        wdata = 64'h0;
        q2_fitted = 1'b1;
        bp_variant = 1'b0;
        num_errors = 0;
        tests_run = 0;
        do_reset(1'b1, 1'b0);
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) begin
                reg_write(ROWS[i].a, ROWS[i].d);
            end
            check_rd("row_read", ROWS[i].a, ROWS[i].e);
        end
        repeat (2) @(posedge sys_clk);
        #1;
        chk_val("clkout_oe", 64'h1, {63'h0, clkout_oe});
        chk_clkout();
        reg_write(OFS_CLOCK_SOURCE_SELECT, 64'(MODE_EXTERNAL_REFERENCE));
        reg_write(OFS_SAMPLE_RATE_REQUEST, 64'h98_9680);
        chk_val("cfg_mode", 64'(RST_MODE), {32'h0, cfg.mode});
        locked = 1'b1;
        sync_master = 1'b1;
        do_start(1'b0, n);
        chk_cnt("lock_cycles", LMIN, LMAX + 1, n);
        chk_val("cfg_mode", 64'(MODE_EXTERNAL_REFERENCE),
                {32'h0, cfg.mode});
        chk_val("cfg_rate", 64'h98_9800, cfg.rate);
        chk_val("ref_sel", 64'h4, {60'h0, ref_sel});
        chk_val("stable", 64'h1, {63'h0, stable});
        // sync enable is registered once more behind the stable level
        @(posedge sys_clk);
        #1;
        chk_val("sync_oe", 64'h1, {63'h0, sync_oe});
        check_rd("out_freq", OFS_CLOCK_OUTPUT_FREQUENCY, 64'h98_9800);
        chk_clkout();
        do_start(1'b0, n);
        chk_cnt("quick_start", 0, 1, n);
        // no lock gives the error level
        reg_write(OFS_CLOCK_SOURCE_SELECT, 64'(MODE_SECONDARY_OSCILLATOR));
        locked = 1'b0;
        do_start(1'b1, n);
        chk_cnt("err_cycles", LMIN, LMAX + 1, n);
        chk_val("stable", 64'h0, {63'h0, stable});
        // same settings after a failure must not bypass the lock check
        do_start(1'b1, n);
        chk_cnt("err_again", LMIN, LMAX + 1, n);
        locked = 1'b1;
        do_start(1'b0, n);
        chk_cnt("restart", LMIN, LMAX + 1, n);
        chk_val("err", 64'h0, {63'h0, err});
        chk_val("ref_sel", 64'h2, {60'h0, ref_sel});
        chk_val("sync_oe", 64'h0, {63'h0, sync_oe});
        reg_write(OFS_CLOCK_OUTPUT_ENABLE, 64'h0);
        repeat (2) @(posedge sys_clk);
        #1;
        chk_val("clkout_oe", 64'h0, {63'h0, clkout_oe});
        check_rd("out_freq", OFS_CLOCK_OUTPUT_FREQUENCY, 64'h0);
        // backplane variant after a second reset
        do_reset(1'b0, 1'b1);
        check_rd("avail", OFS_CLOCK_SOURCES_AVAILABLE, 64'h61);
        reg_write(OFS_CLOCK_SOURCE_SELECT, 64'(MODE_BACKPLANE_REFERENCE));
        check_rd("mode", OFS_CLOCK_SOURCE_SELECT, 64'h40);
        do_start(1'b0, n);
        chk_cnt("lock_cycles", LMIN, LMAX + 1, n);
        chk_val("ref_sel", 64'h8, {60'h0, ref_sel});
        end_of_test();
    end
endmodule : tb
`default_nettype wire
